// ==== rbc_pkg.sv ====
// Package for the reset and bus configuration control block.
// Assumes a single 20 MHz system clock and a synchronous active-low reset.
package rbc_pkg;

  // ****************************************************************
  // Bus configuration codes, as {bus active, config hi, config lo}.
  // ****************************************************************
  localparam logic [2:0] RBC_CODE_DEMUX8 = 3'h0;
  localparam logic [2:0] RBC_CODE_MUX8   = 3'h1;
  localparam logic [2:0] RBC_CODE_MUX16  = 3'h2;
  localparam logic [2:0] RBC_CODE_SINGLE = 3'h4;

  // ****************************************************************
  // Timing and field constants.
  // ****************************************************************
  localparam int          RBC_CLK_NS        = 50;
  localparam int          RBC_RST_MIN_NS    = 100;
  localparam int          RBC_RST_MIN_CYC   =
    (RBC_RST_MIN_NS + RBC_CLK_NS - 1) / RBC_CLK_NS;
  localparam logic [2:0]  RBC_RST_CNT_W_MAX = 3'h7;
  localparam int          RBC_SEG_LO        = 0;
  localparam int          RBC_SEG_HI        = 1;
  localparam logic [15:0] RBC_ZERO16        = 16'h0000;

  // Operating bus modes decoded from the captured straps.
  typedef enum logic [2:0] {
    RBC_BUS_DEMUX8,
    RBC_BUS_MUX8,
    RBC_BUS_MUX16,
    RBC_BUS_SINGLE,
    RBC_BUS_RESERVED
  } rbc_bus_mode_type;

  // One external access request from the CPU core.
  typedef struct packed {
    logic        req;
    logic        fetch;
    logic        write;
    logic [17:0] addr;
    logic [15:0] wdata;
  } rbc_access_type;

  // Port direction and output values from the port registers.
  typedef struct packed {
    logic [15:0] p0_dir;
    logic [15:0] p0_out;
    logic [15:0] p1_dir;
    logic [15:0] p1_out;
    logic [1:0]  p4_dir;
    logic [1:0]  p4_out;
  } rbc_port_cfg_type;

endpackage

// ==== rbc_control.sv ====
// Reset indication, strap capture, trap and power-down control, clock
// prescaler and external bus pin steering for a 16-bit controller core.
// Assumes the core reports instruction execution as one-cycle pulses
// and that board straps stay stable while the reset input is low.
//
// Overview of operation
// - Capture straps during hardware reset, fix bus mode.
// - Decode codes to demux8, mux8, mux16, single.
// - Reset input low long enough enters reset.
// - Reset indication low during any reset.
// - Indication stays low until end-of-init executes.
// - Falling non-maskable input edge requests trap.
// - Power-down with non-maskable input low enters.
// - Power-down with non-maskable input high ignored.
// - CPU clock enable: prescaled or direct variant.
// - Per-pin direction; inputs leave driver off.
// - Segment port drives A16, A17 on external bus.
// - Read strobe on every external read or fetch.
// - Address latch strobe in multiplexed modes.
// - General port carries address in demux8, and in mux modes once demux8 was seen.
`timescale 1ns/10ps
module rbc_control
  import rbc_pkg::*;
#(
  parameter bit PRESCALE = 1'b1
) (
  // Clock and reset.
  input  wire logic             i_sys_clk,
  input  wire logic             i_rstn,
  // Pins from the board.
  input  wire logic             i_reset_input_n,
  input  wire logic             i_bus_active_strap,
  input  wire logic             i_bus_config_strap_hi,
  input  wire logic             i_bus_config_strap_lo,
  input  wire logic             i_nmi_n,
  // Core events and requests.
  input  wire logic             i_sw_reset,
  input  wire logic             i_wdt_reset,
  input  wire logic             i_end_of_init_instruction,
  input  wire logic             i_power_down_instruction,
  input  wire rbc_access_type   i_access,
  input  wire rbc_port_cfg_type i_port_cfg,
  // Status and events to the core.
  output logic                  o_reset_active,
  output logic                  o_nmi_trap,
  output logic                  o_power_down,
  output logic                  o_cpu_clk_en,
  output rbc_bus_mode_type      o_bus_mode,
  // Pins to the board.
  output logic                  o_reset_indication_n,
  output logic                  o_rd_n,
  output logic                  o_ale,
  output logic [15:0]           o_p0_out,
  output logic [15:0]           o_p0_oe,
  output logic [15:0]           o_p1_out,
  output logic [15:0]           o_p1_oe,
  output logic [1:0]            o_p4_out,
  output logic [1:0]            o_p4_oe
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [4:0] sync1_reg, sync1_next, sync2_reg, sync2_next;
  logic       reset_input_n_s, act_s, hi_s, lo_s, nmi_s;

  // Two flops per pin; only the second stage is read by logic.
  // The reset pin stage clears low, so the hardware reset holds until
  // the pin is really seen high and straps are taken from real pins.
  always_comb begin
    sync1_next = {i_reset_input_n, i_bus_active_strap,
                  i_bus_config_strap_hi, i_bus_config_strap_lo, i_nmi_n};
    sync2_next = sync1_reg;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      sync1_reg <= 5'h0F;
      sync2_reg <= 5'h0F;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
    end
  end

  assign {reset_input_n_s, act_s, hi_s, lo_s, nmi_s} = sync2_reg;

  // ****************************************************************
  // Reset sequencing and strap capture.
  // ****************************************************************
  logic [2:0]       low_cnt_reg, low_cnt_next;
  logic             hw_rst_reg, hw_rst_next;
  logic             init_done_reg, init_done_next;
  logic [2:0]       strap_reg, strap_next;
  rbc_bus_mode_type mode_reg, mode_next;
  logic             any_reset;

  // Decode of a captured strap code to a bus mode.
  function automatic rbc_bus_mode_type decode_mode(input logic [2:0] c);
    unique case (c)
      RBC_CODE_DEMUX8: decode_mode = RBC_BUS_DEMUX8;
      RBC_CODE_MUX8:   decode_mode = RBC_BUS_MUX8;
      RBC_CODE_MUX16:  decode_mode = RBC_BUS_MUX16;
      RBC_CODE_SINGLE: decode_mode = RBC_BUS_SINGLE;
      default:         decode_mode = RBC_BUS_RESERVED;
    endcase
  endfunction

  // Short glitches on the reset pin are filtered by a minimum low time.
  always_comb begin
    low_cnt_next = reset_input_n_s ? 3'h0 :
      ((low_cnt_reg == RBC_RST_CNT_W_MAX) ? low_cnt_reg
                                          : low_cnt_reg + 3'h1);
    hw_rst_next  = hw_rst_reg;
    if (reset_input_n_s)
      hw_rst_next = 1'b0;
    else if (int'(low_cnt_reg) + 1 >= RBC_RST_MIN_CYC)
      hw_rst_next = 1'b1;
    any_reset  = hw_rst_reg | i_sw_reset | i_wdt_reset;
    strap_next = strap_reg;
    mode_next  = mode_reg;
    if (hw_rst_reg) begin
      strap_next = {act_s, hi_s, lo_s};
      mode_next  = decode_mode({act_s, hi_s, lo_s});
    end
    init_done_next = init_done_reg;
    if (any_reset)
      init_done_next = 1'b0;
    else if (i_end_of_init_instruction)
      init_done_next = 1'b1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      low_cnt_reg   <= 3'h0;
      hw_rst_reg    <= 1'b1;
      init_done_reg <= 1'b0;
      strap_reg     <= RBC_CODE_SINGLE;
      mode_reg      <= RBC_BUS_SINGLE;
    end else begin
      low_cnt_reg   <= low_cnt_next;
      hw_rst_reg    <= hw_rst_next;
      init_done_reg <= init_done_next;
      strap_reg     <= strap_next;
      mode_reg      <= mode_next;
    end
  end

  assign o_reset_indication_n = init_done_reg;
  assign o_reset_active       = any_reset;
  assign o_bus_mode           = mode_reg;

  // ****************************************************************
  // Non-maskable input, power-down and clock prescaler.
  // ****************************************************************
  logic nmi_d_reg, nmi_d_next, trap_reg, trap_next;
  logic pd_reg, pd_next, div_reg, div_next;

  // Power-down only leaves through reset; the oscillator is not modelled.
  always_comb begin
    nmi_d_next = nmi_s;
    trap_next  = nmi_d_reg & ~nmi_s & ~any_reset;
    pd_next    = pd_reg;
    if (any_reset)
      pd_next = 1'b0;
    else if (i_power_down_instruction && !nmi_s)
      pd_next = 1'b1;
    // A request with the input high leaves the state unchanged.
    div_next = PRESCALE ? ~div_reg : 1'b1;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      nmi_d_reg <= 1'b1;
      trap_reg  <= 1'b0;
      pd_reg    <= 1'b0;
      div_reg   <= 1'b0;
    end else begin
      nmi_d_reg <= nmi_d_next;
      trap_reg  <= trap_next;
      pd_reg    <= pd_next;
      div_reg   <= div_next;
    end
  end

  assign o_nmi_trap   = trap_reg;
  assign o_power_down = pd_reg;
  assign o_cpu_clk_en = div_reg & ~pd_reg;

  // ****************************************************************
  // External bus pin steering.
  // ****************************************************************
  logic        ext, mux, wide, rd_next, ale_next;
  logic [15:0] p0o_n, p0e_n, p1o_n, p1e_n;
  logic [1:0]  p4o_n, p4e_n;
  logic        rd_reg, ale_reg;
  logic [15:0] p0o_reg, p0e_reg, p1o_reg, p1e_reg;
  logic [1:0]  p4o_reg, p4e_reg;
  logic        demux_seen_reg, demux_seen_next;

  // Bus steering is gated off until any reset ends, so bus pins stay quiet in reset.
  always_comb begin
    ext  = ~any_reset & (mode_reg inside {RBC_BUS_DEMUX8, RBC_BUS_MUX8,
                                          RBC_BUS_MUX16});
    mux  = mode_reg inside {RBC_BUS_MUX8, RBC_BUS_MUX16};
    wide = mode_reg == RBC_BUS_MUX16;
    demux_seen_next = demux_seen_reg | (ext & ~mux);
    // Plain port behaviour: driver on only for output pins.
    p0o_n = i_port_cfg.p0_out;
    p0e_n = i_port_cfg.p0_dir;
    p1o_n = i_port_cfg.p1_out;
    p1e_n = i_port_cfg.p1_dir;
    p4o_n = i_port_cfg.p4_out;
    p4e_n = i_port_cfg.p4_dir;
    rd_next  = 1'b1;
    ale_next = 1'b0;
    if (ext) begin
      p4o_n[RBC_SEG_LO] = i_access.addr[16];
      p4o_n[RBC_SEG_HI] = i_access.addr[17];
      p4e_n = 2'h3;
      if (!mux || demux_seen_reg) begin
        p1o_n = i_access.addr[15:0];
        p1e_n = 16'hFFFF;
      end
      if (i_access.req) begin
        rd_next  = i_access.write;
        ale_next = mux;
        if (mux) begin
          p0o_n = wide ? i_access.addr[15:0]
                       : {i_access.addr[15:8], i_access.addr[7:0]};
          p0e_n = 16'hFFFF;
        end else begin
          p0o_n = i_access.write ? i_access.wdata : RBC_ZERO16;
          p0e_n = i_access.write ? 16'hFFFF : 16'hFF00;
        end
      end else begin
        p0e_n = RBC_ZERO16;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rstn) begin
      rd_reg  <= 1'b1;
      ale_reg <= 1'b0;
      p0o_reg <= 16'h0000;
      p0e_reg <= 16'h0000;
      p1o_reg <= 16'h0000;
      p1e_reg <= 16'h0000;
      p4o_reg <= 2'h0;
      p4e_reg <= 2'h0;
      demux_seen_reg <= 1'b0;
    end else begin
      rd_reg  <= rd_next;
      ale_reg <= ale_next;
      p0o_reg <= p0o_n;
      p0e_reg <= p0e_n;
      p1o_reg <= p1o_n;
      p1e_reg <= p1e_n;
      p4o_reg <= p4o_n;
      p4e_reg <= p4e_n;
      demux_seen_reg <= demux_seen_next;
    end
  end

  assign o_rd_n   = rd_reg;
  assign o_ale    = ale_reg;
  assign o_p0_out = p0o_reg;
  assign o_p0_oe  = p0e_reg;
  assign o_p1_out = p1o_reg;
  assign o_p1_oe  = p1e_reg;
  assign o_p4_out = p4o_reg;
  assign o_p4_oe  = p4e_reg;

endmodule

// ==== rbc_control_chk.sv ====
// Checker for the reset and bus configuration control block.
// Sees only top-level ports; bound into every rbc_control instance.
`timescale 1ns/10ps
module rbc_control_chk
  import rbc_pkg::*;
#(
  parameter bit PRESCALE = 1'b1
) (
  // Clock, reset and inputs.
  input wire logic             i_sys_clk,
  input wire logic             i_rstn,
  input wire logic             i_nmi_n,
  input wire logic             i_end_of_init_instruction,
  input wire logic             i_power_down_instruction,
  input wire rbc_access_type   i_access,
  // Outputs under watch.
  input wire logic             o_reset_active,
  input wire logic             o_nmi_trap,
  input wire logic             o_power_down,
  input wire logic             o_cpu_clk_en,
  input wire rbc_bus_mode_type o_bus_mode,
  input wire logic             o_reset_indication_n,
  input wire logic             o_rd_n,
  input wire logic [15:0]      o_p1_out,
  input wire logic [15:0]      o_p1_oe,
  input wire logic [1:0]       o_p4_out
);
  // ***
  // Properties
  // ***
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  // Requests count only outside reset; ext is any external bus.
  wire go  = i_access.req && !o_reset_active;
  wire ext = o_bus_mode inside {RBC_BUS_DEMUX8, RBC_BUS_MUX8, RBC_BUS_MUX16};
  property p_ind; o_reset_active |=> !o_reset_indication_n; endproperty
  a_ind: assert property (p_ind) else $error("Indication high.");
  property p_eoi; $rose(o_reset_indication_n) |-> $past(
    i_end_of_init_instruction) || $past(i_end_of_init_instruction, 2);
  endproperty
  a_eoi: assert property (p_eoi) else $error("Early release.");
  property p_trap; $fell(i_nmi_n) && !o_reset_active |-> ##[1:4] o_nmi_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("No trap.");
  property p_pd; !i_nmi_n [*4] ##0 (i_power_down_instruction &&
    !o_reset_active) |-> ##[1:2] o_power_down; endproperty
  a_pd: assert property (p_pd) else $error("No power-down.");
  property p_nopd; i_nmi_n [*4] ##0 (i_power_down_instruction &&
    !o_power_down) |-> ##1 !o_power_down [*2]; endproperty
  a_nopd: assert property (p_nopd) else $error("Power-down.");
  // The prescaled variant toggles its enable; the direct one holds it.
  property p_clk; !o_reset_active && $past(!o_reset_active) && !o_power_down
    |-> (PRESCALE ? o_cpu_clk_en != $past(o_cpu_clk_en) : o_cpu_clk_en);
  endproperty
  a_clk: assert property (p_clk) else $error("Bad clock enable.");
  property p_rd; go && !i_access.write && ext |=> !o_rd_n &&
    o_p4_out == $past(i_access.addr[17:16]); endproperty
  a_rd: assert property (p_rd) else $error("Bad read.");
  property p_adr; go && o_bus_mode == RBC_BUS_DEMUX8 |=> o_p1_oe ==
    16'hFFFF && o_p1_out == $past(i_access.addr[15:0]); endproperty
  a_adr: assert property (p_adr) else $error("Bad address.");
endmodule
bind rbc_control rbc_control_chk #(.PRESCALE(PRESCALE)) u_chk (.*);

// ==== rbc_board.sv ====
// Board model: strap resistors, reset pin driver and address latch.
// Assumes the bench picks a strap code and asks for reset pulses.
`timescale 1ns/10ps
module rbc_board
  import rbc_pkg::*;
#(
  parameter int HOLD = RBC_RST_MIN_CYC + 2
) (
  // Clock and bench requests.
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_req,
  input  wire logic [2:0]  i_code,
  // Device side pins.
  input  wire logic        i_ale,
  input  wire logic [15:0] i_p0_out,
  output logic             o_reset_input_n,
  output logic [2:0]       o_straps,
  output logic [15:0]      o_latch
);
  // ***
  // Pins
  // ***
  int cnt = 0;
  // Codes 5 and 6 fall back to single-chip; reserved codes 3 and 7 pass through.
  assign o_straps = (i_code inside {3'h5, 3'h6}) ?
                    RBC_CODE_SINGLE : i_code;
  // Pin is held low past the minimum, so a reset always takes.
  assign o_reset_input_n = (cnt == 0);
  // Count down the pin hold; latch the shared lines on the strobe.
  always @(posedge i_sys_clk) begin
    if (i_rst_req) cnt <= HOLD;
    else if (cnt != 0) cnt <= cnt - 1;
    if (i_ale) o_latch <= i_p0_out;
  end
endmodule

// ==== tb_top.sv ====
// Testbench: boots the demux8, mux8, mux16 and single strap codes, runs accesses, resets, trap and
// power-down. Assumes the board model stands on the pins.
`timescale 1ns/10ps
module tb_top;
  import rbc_pkg::*;
  // ***
  // Signals and instances
  // ***
  localparam logic [17:0] ADDR = 18'h2A5C3;
  logic i_sys_clk = 1'b0, i_rstn = 1'b0, i_nmi_n = 1'b1, rst_req = 1'b0;
  logic i_sw_reset = 1'b0, i_wdt_reset = 1'b0;
  logic i_end_of_init_instruction = 1'b0, i_power_down_instruction = 1'b0;
  rbc_access_type   i_access = '{1'b0, 1'b1, 1'b0, ADDR, 16'h0000};
  rbc_port_cfg_type i_port_cfg = '{16'h0, 16'h0, 16'h00F0, 16'h1234,
                                   2'h2, 2'h1};
  wire i_reset_input_n, i_bus_active_strap;
  wire i_bus_config_strap_hi, i_bus_config_strap_lo;
  logic o_reset_active, o_nmi_trap, o_power_down, o_cpu_clk_en;
  logic o_reset_indication_n, o_rd_n, o_ale;
  rbc_bus_mode_type o_bus_mode;
  logic [15:0] o_p0_out, o_p0_oe, o_p1_out, o_p1_oe, lat;
  logic [1:0]  o_p4_out, o_p4_oe;
  logic [2:0]  code = RBC_CODE_SINGLE;
  logic [2:0]  codes [4] = '{RBC_CODE_DEMUX8, RBC_CODE_MUX8,
                             RBC_CODE_MUX16, RBC_CODE_SINGLE};
  int n_fail = 0, n_checks = 0, i, n, m;
  logic d_clk_en;
  rbc_control #(.PRESCALE(1'b1)) u_rbc_control (.*);
  // Direct clock variant, watched only for its clock enable.
  rbc_control #(.PRESCALE(1'b0)) u_rbc_control_direct (
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
    .i_reset_input_n(i_reset_input_n),
    .i_bus_active_strap(i_bus_active_strap),
    .i_bus_config_strap_hi(i_bus_config_strap_hi),
    .i_bus_config_strap_lo(i_bus_config_strap_lo), .i_nmi_n(i_nmi_n),
    .i_sw_reset(i_sw_reset), .i_wdt_reset(i_wdt_reset),
    .i_end_of_init_instruction(i_end_of_init_instruction),
    .i_power_down_instruction(i_power_down_instruction),
    .i_access(i_access), .i_port_cfg(i_port_cfg),
    .o_reset_active(), .o_nmi_trap(), .o_power_down(),
    .o_cpu_clk_en(d_clk_en), .o_bus_mode(), .o_reset_indication_n(),
    .o_rd_n(), .o_ale(), .o_p0_out(), .o_p0_oe(), .o_p1_out(),
    .o_p1_oe(), .o_p4_out(), .o_p4_oe());
  rbc_board u_rbc_board (.i_sys_clk(i_sys_clk), .i_rst_req(rst_req),
    .i_code(code), .i_ale(o_ale), .i_p0_out(o_p0_out), .o_latch(lat),
    .o_reset_input_n(i_reset_input_n), .o_straps({i_bus_active_strap,
    i_bus_config_strap_hi, i_bus_config_strap_lo}));
  // Clock of 50 ns.
  always #25 i_sys_clk = ~i_sys_clk;
  // ***
  // Tasks
  // ***
  // Inputs change 2 ns after an edge, away from the sampling moment.
  task automatic step();
    @(posedge i_sys_clk);
    #2;
  endtask
  task automatic chk(input logic [17:0] got, input logic [17:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    if (n_fail == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Bounded wait for the reset sequence to finish.
  task automatic wait_idle();
    int k;
    for (k = 0; k < 40 && o_reset_active !== 1'b0; k++) step();
    if (o_reset_active !== 1'b0) begin
      n_fail++;
      conclude();
    end
  endtask
  task automatic boot(input logic [2:0] c);
    code = c;
    rst_req = 1'b1;
    step();
    rst_req = 1'b0;
    repeat (6) step();
    wait_idle();
  endtask
  task automatic eoi_pulse();
    i_end_of_init_instruction = 1'b1;
    step();
    i_end_of_init_instruction = 1'b0;
    step();
  endtask
  task automatic pd_pulse();
    i_power_down_instruction = 1'b1;
    step();
    i_power_down_instruction = 1'b0;
    step();
  endtask
  // ***
  // Sequence
  // ***
  initial begin
    repeat (8) step();
    i_rstn = 1'b1;
    for (i = 0; i < 4; i++) begin
      boot(codes[i]);
      chk(18'(o_bus_mode), 18'(i));
      chk(18'(o_reset_indication_n), 18'h0);
      eoi_pulse();
      chk(18'(o_reset_indication_n), 18'h1);
      i_access.req = 1'b1;
      i_access.fetch = i[0];
      step();
      i_access.req = 1'b0;
      chk(18'(o_rd_n), 18'(i == 3));
      chk(18'(o_ale), 18'(i == 1 || i == 2));
      chk(18'(o_p4_out), (i < 3) ? 18'h2 : 18'h1);
      chk(18'(o_p4_oe), (i < 3) ? 18'h3 : 18'h2);
      if (i < 3) chk(18'(o_p1_out), 18'(ADDR[15:0]));
      if (i == 3) chk(18'(o_p1_oe), 18'h00F0);
      chk(18'(o_p0_oe), (i == 0) ? 18'hFF00 :
          ((i == 3) ? 18'h0000 : 18'hFFFF));
      step();
      if (i == 1 || i == 2) chk(18'(lat), 18'(ADDR[15:0]));
      // A demultiplexed write drives data and leaves the read strobe off.
      if (i == 0) begin
        i_access = '{1'b1, 1'b0, 1'b1, ADDR, 16'h3C5A};
        step();
        i_access.req = 1'b0;
        chk(18'(o_rd_n), 18'h1);
        chk(18'(o_p0_out), 18'h3C5A);
        chk(18'(o_p0_oe), 18'hFFFF);
        step();
        i_access.write = 1'b0;
      end
    end
    // Software then watchdog reset, with end-of-init in the same cycle.
    for (i = 0; i < 2; i++) begin
      {i_wdt_reset, i_sw_reset} = 2'(1 << i);
      i_end_of_init_instruction = 1'b1;
      step();
      {i_wdt_reset, i_sw_reset} = 2'h0;
      i_end_of_init_instruction = 1'b0;
      step();
      chk(18'(o_reset_indication_n), 18'h0);
      wait_idle();
      eoi_pulse();
      chk(18'(o_reset_indication_n), 18'h1);
    end
    n = 0;
    m = 0;
    repeat (4) begin
      step();
      n += int'(o_cpu_clk_en);
      m += int'(d_clk_en);
    end
    chk(18'(n), 18'h2);
    chk(18'(m), 18'h4);
    pd_pulse();
    step();
    chk(18'(o_power_down), 18'h0);
    i_nmi_n = 1'b0;
    n = 0;
    repeat (6) begin
      step();
      n += int'(o_nmi_trap);
    end
    chk(18'(n), 18'h1);
    pd_pulse();
    chk(18'(o_power_down), 18'h1);
    step();
    chk(18'(o_cpu_clk_en), 18'h0);
    chk(18'(d_clk_en), 18'h0);
    conclude();
  end
endmodule
